// ### common/emrm_pkg.sv
// constants and carrier types for the energy meter register map
`default_nettype none
package emrm_pkg;
   // byte offsets, multi-byte registers little endian from the base
   localparam logic [8:0] OFF_VERSION    = 9'h000;
   localparam logic [8:0] OFF_STATUS     = 9'h001;
   localparam logic [8:0] OFF_CONTROL    = 9'h002;
   localparam logic [8:0] OFF_I_RAW      = 9'h003;
   localparam logic [8:0] OFF_I_CAL      = 9'h005;
   localparam logic [8:0] OFF_V_RAW      = 9'h007;
   localparam logic [8:0] OFF_V_CAL      = 9'h009;
   localparam logic [8:0] OFF_FREQ       = 9'h00B;
   localparam logic [8:0] OFF_P_ACT      = 9'h00D;
   localparam logic [8:0] OFF_P_REACT    = 9'h011;
   localparam logic [8:0] OFF_P_APP      = 9'h015;
   localparam logic [8:0] OFF_PF         = 9'h019;
   localparam logic [8:0] OFF_USE_PHASE  = 9'h01B;
   localparam logic [8:0] OFF_USE_IGAIN  = 9'h01C;
   localparam logic [8:0] OFF_USE_PGAIN  = 9'h01E;
   localparam logic [8:0] OFF_USE_QGAIN  = 9'h020;
   localparam logic [8:0] OFF_USE_PNUM   = 9'h022;
   localparam logic [8:0] OFF_USE_PSHIFT = 9'h024;
   localparam logic [8:0] OFF_USE_QNUM   = 9'h025;
   localparam logic [8:0] OFF_USE_QSHIFT = 9'h027;
   localparam logic [8:0] OFF_PHASE_LO   = 9'h028;
   localparam logic [8:0] OFF_PHASE_HI   = 9'h029;
   localparam logic [8:0] OFF_VGAIN      = 9'h02A;
   localparam logic [8:0] OFF_IGAIN_LO   = 9'h02C;
   localparam logic [8:0] OFF_IGAIN_HI   = 9'h02E;
   localparam logic [8:0] OFF_PGAIN_LO   = 9'h030;
   localparam logic [8:0] OFF_PGAIN_HI   = 9'h032;
   localparam logic [8:0] OFF_PNUM_LO    = 9'h034;
   localparam logic [8:0] OFF_PNUM_HI    = 9'h036;
   localparam logic [8:0] OFF_PSHIFT_LO  = 9'h038;
   localparam logic [8:0] OFF_PSHIFT_HI  = 9'h039;
   localparam logic [8:0] OFF_QGAIN_LO   = 9'h03A;
   localparam logic [8:0] OFF_QGAIN_HI   = 9'h03C;
   localparam logic [8:0] OFF_QNUM_LO    = 9'h03E;
   localparam logic [8:0] OFF_QNUM_HI    = 9'h040;
   localparam logic [8:0] OFF_QSHIFT_LO  = 9'h042;
   localparam logic [8:0] OFF_QSHIFT_HI  = 9'h043;
   localparam logic [8:0] OFF_METER_K    = 9'h044;
   localparam logic [8:0] OFF_PULSE_MS   = 9'h046;
   localparam logic [8:0] OFF_IDLE_THR   = 9'h047;
   localparam logic [8:0] OFF_AVG_EXP    = 9'h048;
   localparam logic [8:0] OFF_E_ACT      = 9'h100;
   localparam logic [8:0] OFF_E_REACT    = 9'h104;
   // control and status field positions
   localparam int BIT_REGION    = 0;
   localparam int BIT_CAL_MODE  = 0;
   localparam int BIT_FORCE     = 2;
   localparam int BIT_SEL_LOW   = 3;
   localparam int BIT_FIRST_CYC = 4;
   localparam logic [7:0] CTRL_WR_MASK = 8'h0D;
   localparam logic [7:0] RESET_BYTE   = 8'h00;
   // hysteresis in calibrated current codes: 5.000 A up, 0.400 A down
   localparam logic [15:0] UP_THRESHOLD   = 16'h1388;
   localparam logic [15:0] DOWN_THRESHOLD = 16'h0190;
   // pulse timing at the 40 ns clock
   localparam int CLOCK_PERIOD_NS = 40;
   localparam int MS_NS           = 1000000;
   localparam int CYCLES_PER_MS   = MS_NS / CLOCK_PERIOD_NS;
   // results delivered by the calculation engine
   typedef struct packed {
      logic [15:0] i_raw;
      logic [15:0] i_cal;
      logic [15:0] v_raw;
      logic [15:0] v_cal;
      logic [15:0] freq;
      logic [31:0] p_act;
      logic [31:0] p_react;
      logic [31:0] p_app;
      logic [15:0] pf;
   } emrm_meas_t;
   // calibration copy that the engine works with
   typedef struct packed {
      logic [7:0]  phase;
      logic [15:0] i_gain;
      logic [15:0] p_gain;
      logic [15:0] q_gain;
      logic [15:0] p_num;
      logic [7:0]  p_shift;
      logic [15:0] q_num;
      logic [7:0]  q_shift;
   } emrm_in_use_t;
   // energy increments from the engine
   typedef struct packed {
      logic        p_valid;
      logic [31:0] p_inc;
      logic        q_valid;
      logic [31:0] q_inc;
   } emrm_energy_t;
endpackage : emrm_pkg
`default_nettype wire

// ### core/emrm_core.sv
// register map and region control of the energy meter engine
// Functional notes
// - status bit 0 shows current region, one is high region
// - unimplemented status and control bits read zero
// - control bit 0 set by host enables auto-calibration; the core only uses it to gate control bit 4
// - control bit 2 forces region from selection bit, else automatic
// - control bit 3 one means low region, zero high
// - read-only control bit 4 high for first line cycle after change; set only while control bit 0 is one
// - energy accumulation off while calibrated current below threshold
// - computation averaged over two to the n line cycles; the core caps n at the counter width
// - calibration pulse width in milliseconds from duration register
// - meter constant held in a 16-bit read/write register
// - read-only version identifier holds fixed value
// - raw and calibrated current rms, 16-bit read-only
// - raw and calibrated voltage rms, 16-bit read-only
// - separate writable phase delays for low and high regions
// - 32-bit active and reactive energy counters, read/write
// - in-use copies loaded from low or high set by region
// - automatic region switch with hysteresis between 0.4 and 5 A
`timescale 1ns/10ps
`default_nettype none
module emrm_core #(
   parameter logic [7:0] VERSION_VALUE = 8'hA5, // arbitrary value
   parameter int         MS_CYCLES     = emrm_pkg::CYCLES_PER_MS,
   parameter int         AVG_WIDTH     = 16
) (
   input  wire logic                   clock,
   input  wire logic                   rst_b,
   input  wire logic [8:0]             reg_addr,
   input  wire logic [7:0]             reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic [7:0]                  reg_rdata,
   output logic                        reg_rvalid,
   input  wire emrm_pkg::emrm_meas_t   meas,
   input  wire emrm_pkg::emrm_energy_t energy_in,
   input  wire logic                   line_cycle_tick,
   input  wire logic                   pulse_request,
   output emrm_pkg::emrm_in_use_t      in_use,
   output logic [15:0]                 voltage_gain,
   output logic [15:0]                 pulses_per_kwh,
   output logic                        region_high,
   output logic                        accumulate_enable,
   output logic                        averaging_done,
   output logic                        calibration_pulse_output
);
   import emrm_pkg::*;

   // address helpers: in_rng serves the read and write decoders, pick only the read decoder
   function automatic logic in_rng(input logic [8:0] a,
                                   input logic [8:0] base,
                                   input logic [8:0] n);
      in_rng = (a >= base) && (a < base + n);
   endfunction : in_rng

   function automatic logic [7:0] pick(input logic [8:0]  a,
                                       input logic [8:0]  base,
                                       input logic [31:0] v);
      logic [8:0] off;
      off  = a - base;
      pick = 8'(v >> {off[1:0], 3'b000});
   endfunction : pick

   logic [7:0]   cal_mem [OFF_PHASE_LO:OFF_AVG_EXP];
   logic [7:0]   control;
   logic [31:0]  e_act;
   logic [31:0]  e_react;
   logic [31:0]  next_e_act;
   logic [31:0]  next_e_react;
   logic         first_cycle_after_band_change;
   logic         next_region;
   logic [7:0]   next_rdata;
   logic [AVG_WIDTH-1:0] avg_cnt;
   logic [7:0]   ms_left;
   logic [31:0]  ms_cyc;
   emrm_in_use_t next_in_use;

   wire logic       wr_cal   = reg_wr && in_rng(reg_addr, OFF_PHASE_LO,
                                  OFF_AVG_EXP - OFF_PHASE_LO + 9'h001);
   wire logic       wr_ctrl  = reg_wr && (reg_addr == OFF_CONTROL);
   wire logic       cal_mode = control[BIT_CAL_MODE];
   wire logic       force_rg = control[BIT_FORCE];
   wire logic       sel_low  = control[BIT_SEL_LOW];
   wire logic [7:0] pulse_ms = cal_mem[OFF_PULSE_MS];
   wire logic [7:0] idle_thr = cal_mem[OFF_IDLE_THR];
   wire logic [7:0] avg_exp  = cal_mem[OFF_AVG_EXP];
   wire logic [7:0] status   = {7'h00, region_high};
   wire logic [7:0] ctrl_rd  = {3'h0, first_cycle_after_band_change,
                                control[3:2], 1'b0, control[0]};

   // calibration bytes, both region copies stored side by side
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = OFF_PHASE_LO; i <= OFF_AVG_EXP; i++) begin
            cal_mem[i] <= RESET_BYTE;
         end
      end else if (wr_cal) begin
         cal_mem[reg_addr] <= reg_wdata;
      end
   end

   // only the documented writable control bits are stored
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         control <= RESET_BYTE;
      end else if (wr_ctrl) begin
         control <= reg_wdata & CTRL_WR_MASK;
      end
   end

   // region choice: selection bit inverts polarity against status
   always_comb begin
      next_region = region_high;
      if (force_rg) begin
         next_region = !sel_low;
      end else if (!region_high && meas.i_cal >= UP_THRESHOLD) begin
         next_region = 1'b1;
      end else if (region_high && meas.i_cal < DOWN_THRESHOLD) begin
         next_region = 1'b0;
      end
   end

   // region and the first-cycle flag move only on line cycle ticks
   // so the engine never sees a gain swap in mid cycle
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         region_high                   <= 1'b0;
         first_cycle_after_band_change <= 1'b0;
      end else if (line_cycle_tick) begin
         region_high                   <= next_region;
         first_cycle_after_band_change <= cal_mode &&
                                          (next_region != region_high);
      end
   end

   // in-use copies follow the region one clock later
   assign next_in_use.phase   = region_high ? cal_mem[OFF_PHASE_HI]
                                            : cal_mem[OFF_PHASE_LO];
   assign next_in_use.i_gain  = region_high
      ? {cal_mem[OFF_IGAIN_HI + 9'h001], cal_mem[OFF_IGAIN_HI]}
      : {cal_mem[OFF_IGAIN_LO + 9'h001], cal_mem[OFF_IGAIN_LO]};
   assign next_in_use.p_gain  = region_high
      ? {cal_mem[OFF_PGAIN_HI + 9'h001], cal_mem[OFF_PGAIN_HI]}
      : {cal_mem[OFF_PGAIN_LO + 9'h001], cal_mem[OFF_PGAIN_LO]};
   assign next_in_use.q_gain  = region_high
      ? {cal_mem[OFF_QGAIN_HI + 9'h001], cal_mem[OFF_QGAIN_HI]}
      : {cal_mem[OFF_QGAIN_LO + 9'h001], cal_mem[OFF_QGAIN_LO]};
   assign next_in_use.p_num   = region_high
      ? {cal_mem[OFF_PNUM_HI + 9'h001], cal_mem[OFF_PNUM_HI]}
      : {cal_mem[OFF_PNUM_LO + 9'h001], cal_mem[OFF_PNUM_LO]};
   assign next_in_use.p_shift = region_high ? cal_mem[OFF_PSHIFT_HI]
                                            : cal_mem[OFF_PSHIFT_LO];
   assign next_in_use.q_num   = region_high
      ? {cal_mem[OFF_QNUM_HI + 9'h001], cal_mem[OFF_QNUM_HI]}
      : {cal_mem[OFF_QNUM_LO + 9'h001], cal_mem[OFF_QNUM_LO]};
   assign next_in_use.q_shift = region_high ? cal_mem[OFF_QSHIFT_HI]
                                            : cal_mem[OFF_QSHIFT_LO];

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         in_use <= '0;
      end else begin
         in_use <= next_in_use;
      end
   end

   assign voltage_gain   = {cal_mem[OFF_VGAIN + 9'h001],
                            cal_mem[OFF_VGAIN]};
   assign pulses_per_kwh = {cal_mem[OFF_METER_K + 9'h001],
                            cal_mem[OFF_METER_K]};

   // no-load gate: increments below threshold are dropped
   assign accumulate_enable = meas.i_cal >= {8'h00, idle_thr};

   // energy counters; a host byte write beats an increment
   always_comb begin
      next_e_act   = e_act;
      next_e_react = e_react;
      if (accumulate_enable && energy_in.p_valid) begin
         next_e_act = e_act + energy_in.p_inc;
      end
      if (accumulate_enable && energy_in.q_valid) begin
         next_e_react = e_react + energy_in.q_inc;
      end
      for (int b = 0; b < 4; b++) begin
         if (reg_wr && reg_addr == OFF_E_ACT + 9'(b)) begin
            next_e_act[8*b +: 8] = reg_wdata;
         end
         if (reg_wr && reg_addr == OFF_E_REACT + 9'(b)) begin
            next_e_react[8*b +: 8] = reg_wdata;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         e_act   <= '0;
         e_react <= '0;
      end else begin
         e_act   <= next_e_act;
         e_react <= next_e_react;
      end
   end

   // averaging window of 2^n line cycles; n capped at counter width
   wire logic [AVG_WIDTH-1:0] avg_mask =
      (avg_exp >= 8'(AVG_WIDTH)) ? '1
      : ((AVG_WIDTH'(1) << avg_exp) - AVG_WIDTH'(1));
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         avg_cnt        <= '0;
         averaging_done <= 1'b0;
      end else begin
         averaging_done <= line_cycle_tick && (avg_cnt >= avg_mask);
         if (line_cycle_tick) begin
            avg_cnt <= (avg_cnt >= avg_mask) ? '0
                       : avg_cnt + AVG_WIDTH'(1);
         end
      end
   end

   // calibration pulse; requests during a pulse are merged into it
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ms_left                  <= '0;
         ms_cyc                   <= '0;
         calibration_pulse_output <= 1'b0;
      end else begin
         if (ms_left == 8'h00) begin
            calibration_pulse_output <= pulse_request &&
                                        (pulse_ms != 8'h00);
            if (pulse_request) begin
               ms_left <= pulse_ms;
               ms_cyc  <= '0;
            end
         end else if (ms_cyc == 32'(MS_CYCLES - 1)) begin
            ms_cyc  <= '0;
            ms_left <= ms_left - 8'h01;
            calibration_pulse_output <= (ms_left != 8'h01);
         end else begin
            ms_cyc <= ms_cyc + 32'h1;
         end
      end
   end

   // read decoder, byte within a field picked by offset from its base
   always_comb begin
      next_rdata = 8'h00;
      case (1'b1)
         reg_addr == OFF_VERSION:  next_rdata = VERSION_VALUE;
         reg_addr == OFF_STATUS:   next_rdata = status;
         reg_addr == OFF_CONTROL:  next_rdata = ctrl_rd;
         in_rng(reg_addr, OFF_I_RAW, 9'h2):
            next_rdata = pick(reg_addr, OFF_I_RAW, 32'(meas.i_raw));
         in_rng(reg_addr, OFF_I_CAL, 9'h2):
            next_rdata = pick(reg_addr, OFF_I_CAL, 32'(meas.i_cal));
         in_rng(reg_addr, OFF_V_RAW, 9'h2):
            next_rdata = pick(reg_addr, OFF_V_RAW, 32'(meas.v_raw));
         in_rng(reg_addr, OFF_V_CAL, 9'h2):
            next_rdata = pick(reg_addr, OFF_V_CAL, 32'(meas.v_cal));
         in_rng(reg_addr, OFF_FREQ, 9'h2):
            next_rdata = pick(reg_addr, OFF_FREQ, 32'(meas.freq));
         in_rng(reg_addr, OFF_P_ACT, 9'h4):
            next_rdata = pick(reg_addr, OFF_P_ACT, meas.p_act);
         in_rng(reg_addr, OFF_P_REACT, 9'h4):
            next_rdata = pick(reg_addr, OFF_P_REACT, meas.p_react);
         in_rng(reg_addr, OFF_P_APP, 9'h4):
            next_rdata = pick(reg_addr, OFF_P_APP, meas.p_app);
         in_rng(reg_addr, OFF_PF, 9'h2):
            next_rdata = pick(reg_addr, OFF_PF, 32'(meas.pf));
         reg_addr == OFF_USE_PHASE: next_rdata = in_use.phase;
         in_rng(reg_addr, OFF_USE_IGAIN, 9'h2):
            next_rdata = pick(reg_addr, OFF_USE_IGAIN, 32'(in_use.i_gain));
         in_rng(reg_addr, OFF_USE_PGAIN, 9'h2):
            next_rdata = pick(reg_addr, OFF_USE_PGAIN, 32'(in_use.p_gain));
         in_rng(reg_addr, OFF_USE_QGAIN, 9'h2):
            next_rdata = pick(reg_addr, OFF_USE_QGAIN, 32'(in_use.q_gain));
         in_rng(reg_addr, OFF_USE_PNUM, 9'h2):
            next_rdata = pick(reg_addr, OFF_USE_PNUM, 32'(in_use.p_num));
         reg_addr == OFF_USE_PSHIFT: next_rdata = in_use.p_shift;
         in_rng(reg_addr, OFF_USE_QNUM, 9'h2):
            next_rdata = pick(reg_addr, OFF_USE_QNUM, 32'(in_use.q_num));
         reg_addr == OFF_USE_QSHIFT: next_rdata = in_use.q_shift;
         in_rng(reg_addr, OFF_PHASE_LO,
                OFF_AVG_EXP - OFF_PHASE_LO + 9'h001):
            next_rdata = cal_mem[reg_addr];
         in_rng(reg_addr, OFF_E_ACT, 9'h4):
            next_rdata = pick(reg_addr, OFF_E_ACT, e_act);
         in_rng(reg_addr, OFF_E_REACT, 9'h4):
            next_rdata = pick(reg_addr, OFF_E_REACT, e_react);
         default: next_rdata = 8'h00;
      endcase
   end

   // read answer one clock after the strobe; unmapped reads give zero
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   // checks next to the logic they guard
   sequence s_band_change;
      line_cycle_tick && cal_mode && (next_region != region_high);
   endsequence

   property p_status_bits;
      @(posedge clock) disable iff (!rst_b)
      (reg_rd && reg_addr == OFF_STATUS) |=>
         reg_rdata == {7'h00, $past(region_high)};
   endproperty
   a_status_bits: assert property (p_status_bits)
      else $error("status read wrong");

   property p_ctrl_zero;
      @(posedge clock) disable iff (!rst_b)
      (reg_rd && reg_addr == OFF_CONTROL) |=>
         (reg_rdata[7:5] == 3'h0) && !reg_rdata[1];
   endproperty
   a_ctrl_zero: assert property (p_ctrl_zero)
      else $error("control unimplemented bits not zero");

   property p_forced;
      @(posedge clock) disable iff (!rst_b)
      (line_cycle_tick && force_rg) |=> region_high == !$past(sel_low);
   endproperty
   a_forced: assert property (p_forced)
      else $error("forced region not applied");

   property p_first_cycle;
      @(posedge clock) disable iff (!rst_b)
      s_band_change |=> first_cycle_after_band_change;
   endproperty
   a_first_cycle: assert property (p_first_cycle)
      else $error("first cycle flag missing");

   property p_idle;
      @(posedge clock) disable iff (!rst_b)
      (!accumulate_enable && !reg_wr) |=> $stable(e_act);
   endproperty
   a_idle: assert property (p_idle)
      else $error("energy accumulated below threshold");

   property p_avg_zero;
      @(posedge clock) disable iff (!rst_b)
      (line_cycle_tick && avg_exp == 8'h00) |=> averaging_done;
   endproperty
   a_avg_zero: assert property (p_avg_zero)
      else $error("single cycle averaging missed");

   property p_pulse_start;
      @(posedge clock) disable iff (!rst_b)
      $rose(calibration_pulse_output) |->
         $past(pulse_request) && $past(pulse_ms) != 8'h00;
   endproperty
   a_pulse_start: assert property (p_pulse_start)
      else $error("pulse without request");

   property p_in_use;
      @(posedge clock) disable iff (!rst_b)
      region_high |=> in_use.phase == $past(cal_mem[OFF_PHASE_HI]);
   endproperty
   a_in_use: assert property (p_in_use)
      else $error("in-use phase not from high copy");

   property p_energy_byte;
      @(posedge clock) disable iff (!rst_b)
      (reg_wr && reg_addr == OFF_E_ACT) |=>
         e_act[7:0] == $past(reg_wdata);
   endproperty
   a_energy_byte: assert property (p_energy_byte)
      else $error("energy low byte not written");

endmodule : emrm_core
`default_nettype wire

// ### verif/emrm_host_model.sv
// calibration host model driving the register port of the meter
`timescale 1ns/10ps
`default_nettype none
module emrm_host_model (
   input  wire logic       clock,
   input  wire logic       rst_b,
   input  wire logic       cmd_go,
   input  wire logic       cmd_we,
   input  wire logic [8:0] cmd_addr,
   input  wire logic [7:0] cmd_data,
   output logic [8:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd
);
   // one strobe per byte; idle lines toggle so stale values never match
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         reg_wr    <= 1'b0;
         reg_rd    <= 1'b0;
         reg_addr  <= 9'h000;
         reg_wdata <= 8'h00;
      end else begin
         reg_wr    <= cmd_go & cmd_we;
         reg_rd    <= cmd_go & ~cmd_we;
         reg_addr  <= cmd_go ? cmd_addr : ~reg_addr;
         reg_wdata <= cmd_go ? cmd_data : ~reg_wdata;
      end
   end
endmodule : emrm_host_model
`default_nettype wire

// ### verif/tb_top.sv
// self-checking bench for the energy meter register map
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import emrm_pkg::*;
   typedef struct packed {
      logic       wr;
      logic [8:0] addr;
      logic [7:0] wd;
      logic [7:0] ex;
   } emrm_row_t;
   localparam logic [7:0] VER  = 8'h5C; // arbitrary value
   localparam int         NROW = 20;
   logic         clock, rst_b, go, we, tick, preq;
   logic [8:0]   c_addr, reg_addr;
   logic [7:0]   c_data, reg_wdata, reg_rdata;
   logic         reg_wr, reg_rd, reg_rvalid, region_high;
   logic         acc_en, avg_done, cf;
   logic [15:0]  voltage_gain, pulses_per_kwh;
   emrm_meas_t   meas;
   emrm_in_use_t in_use;
   emrm_energy_t energy_in;
   emrm_row_t    rows [NROW];
   int failures = 0, samples_checked = 0, dn = 0, hi = 0, b0, i;
   emrm_host_model i_host (.clock(clock), .rst_b(rst_b), .cmd_go(go),
      .cmd_we(we), .cmd_addr(c_addr), .cmd_data(c_data),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd));
   emrm_core #(.VERSION_VALUE(VER), .MS_CYCLES(4)) i_dut (.clock(clock),
      .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .meas(meas), .energy_in(energy_in),
      .line_cycle_tick(tick), .pulse_request(preq), .in_use(in_use),
      .voltage_gain(voltage_gain), .pulses_per_kwh(pulses_per_kwh),
      .region_high(region_high), .accumulate_enable(acc_en),
      .averaging_done(avg_done), .calibration_pulse_output(cf));
   // 25 MHz clock
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // counts averaging strobes and pulse-high cycles
   always @(posedge clock) begin
      if (avg_done === 1'b1) dn <= dn + 1;
      if (cf === 1'b1) hi <= hi + 1;
   end
   task automatic results();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   // request is launched after an edge and withdrawn at the next one
   task automatic send(input logic w, input logic [8:0] a,
                       input logic [7:0] d);
      we     <= w;
      c_addr <= a;
      c_data <= d;
      go     <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      @(posedge clock);
   endtask : send
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      send(1'b1, a, d);
      @(posedge clock);
   endtask : wr
   // bounded wait for the answer strobe, data taken at that edge
   task automatic rd(input logic [8:0] a, input logic [7:0] e);
      int n;
      n = 0;
      send(1'b0, a, 8'h00);
      do begin
         @(posedge clock);
         n++;
      end while (reg_rvalid !== 1'b1 && n < 8);
      if (n == 8 && reg_rvalid !== 1'b1) begin
         failures++;
         results();
      end else begin
         chk({8'h00, reg_rdata}, {8'h00, e});
      end
   endtask : rd
   task automatic line_tick();
      tick <= 1'b1;
      @(posedge clock);
      tick <= 1'b0;
      @(posedge clock);
   endtask : line_tick
   initial begin
      rst_b = 1'b0;
      {go, we, tick, preq, c_addr, c_data, energy_in} = '0;
      meas = '0;
      meas.i_raw = 16'h1234;
      meas.i_cal = 16'h0040;
      meas.v_raw = 16'h5678;
      meas.v_cal = 16'h0898;
      rows = '{'{1'b0, 9'h000, 8'h00, VER}, '{1'b1, 9'h000, 8'h5A, VER},
         '{1'b0, 9'h001, 8'h00, 8'h00}, '{1'b1, 9'h002, 8'hFF, 8'h0D},
         '{1'b1, 9'h002, 8'h00, 8'h00}, '{1'b0, 9'h003, 8'h00, 8'h34},
         '{1'b0, 9'h004, 8'h00, 8'h12}, '{1'b1, 9'h005, 8'hFF, 8'h40},
         '{1'b0, 9'h007, 8'h00, 8'h78}, '{1'b0, 9'h008, 8'h00, 8'h56},
         '{1'b0, 9'h009, 8'h00, 8'h98}, '{1'b1, 9'h028, 8'h11, 8'h11},
         '{1'b1, 9'h029, 8'h22, 8'h22}, '{1'b1, 9'h044, 8'hC8, 8'hC8},
         '{1'b1, 9'h045, 8'h01, 8'h01}, '{1'b1, 9'h103, 8'h80, 8'h80},
         '{1'b1, 9'h104, 8'h7E, 8'h7E}, '{1'b1, 9'h0FF, 8'h77, 8'h00},
         '{1'b1, 9'h049, 8'h33, 8'h00}, '{1'b0, 9'h1FF, 8'h00, 8'h00}};
      repeat (4) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      for (i = 0; i < NROW; i++) begin
         if (rows[i].wr) wr(rows[i].addr, rows[i].wd);
         rd(rows[i].addr, rows[i].ex);
      end
      chk(pulses_per_kwh, 16'h01C8);
      wr(OFF_VGAIN + 9'h001, 8'h9A);
      chk(voltage_gain, 16'h9A00);
      // forced region follows the selection bit, inverse polarity
      wr(OFF_IGAIN_HI, 8'hAB);
      wr(OFF_CONTROL, 8'h04);
      line_tick();
      chk(16'(region_high), 16'h0001);
      @(posedge clock);
      chk(in_use.i_gain, 16'h00AB);
      rd(OFF_STATUS, 8'h01);
      wr(OFF_CONTROL, 8'h0C);
      line_tick();
      chk(16'(region_high), 16'h0000);
      @(posedge clock);
      chk(16'(in_use.phase), 16'h0011);
      // automatic selection: thresholds and the first-cycle flag
      wr(OFF_CONTROL, 8'h01);
      meas.i_cal <= 16'h1387;
      line_tick();
      chk(16'(region_high), 16'h0000);
      meas.i_cal <= 16'h1388;
      line_tick();
      chk(16'(region_high), 16'h0001);
      rd(OFF_CONTROL, 8'h11);
      line_tick();
      rd(OFF_CONTROL, 8'h01);
      meas.i_cal <= 16'h0190;
      line_tick();
      chk(16'(region_high), 16'h0001);
      meas.i_cal <= 16'h018F;
      line_tick();
      chk(16'(region_high), 16'h0000);
      // idle threshold gates accumulation at the exact boundary
      wr(OFF_IDLE_THR, 8'h20);
      wr(OFF_E_ACT, 8'h10);
      meas.i_cal <= 16'h001F;
      energy_in  <= {1'b1, 32'h0000_0005, 1'b1, 32'h0000_0003};
      @(posedge clock);
      energy_in <= '0;
      chk(16'(acc_en), 16'h0000);
      rd(OFF_E_ACT, 8'h10);
      meas.i_cal <= 16'h0020;
      energy_in  <= {1'b1, 32'h0000_0005, 1'b1, 32'h0000_0003};
      @(posedge clock);
      energy_in <= '0;
      chk(16'(acc_en), 16'h0001);
      rd(OFF_E_ACT, 8'h15);
      rd(OFF_E_REACT, 8'h81);
      // window of two ticks gives two strobes in four ticks
      wr(OFF_AVG_EXP, 8'h01);
      b0 = dn;
      repeat (4) line_tick();
      @(posedge clock);
      chk(16'(dn - b0), 16'h0002);
      // two ms at four cycles per ms gives eight high cycles
      wr(OFF_PULSE_MS, 8'h02);
      b0 = hi;
      preq <= 1'b1;
      @(posedge clock);
      preq <= 1'b0;
      repeat (12) @(posedge clock);
      chk(16'(hi - b0), 16'h0008);
      // second reset clears the writable registers
      rst_b <= 1'b0;
      repeat (4) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      chk(pulses_per_kwh, 16'h0000);
      rd(OFF_PHASE_LO, 8'h00);
      results();
   end
endmodule : tb_top
`default_nettype wire
